//--- verilog/gpc_port_unit.sv
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ps
module gpc_port_unit
  import gpc_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // first port pins
  input wire logic [7:0] first_pin_i,
  output logic [7:0] first_pin_o,
  output logic [7:0] first_pin_oe,
  output logic [7:0] first_pin_weak,
  output logic [7:0] first_pull_up,
  output logic [7:0] first_pull_down,
  // second port pins
  input wire logic [7:0] second_pin_i,
  output logic [7:0] second_pin_o,
  output logic [7:0] second_pin_oe,
  output logic [7:0] second_pin_weak,
  output logic [7:0] second_pull_up,
  output logic [7:0] second_pull_down,
  // edge port pins
  input wire logic [7:0] edge_pin_i,
  output logic [7:0] edge_pin_o,
  output logic [7:0] edge_pin_oe,
  output logic [7:0] edge_pin_weak,
  output logic [7:0] edge_pull_up,
  output logic [7:0] edge_pull_down,
  // interrupt
  output logic irq
);

  // software registers
  logic [7:0] first_data_q;
  logic [7:0] first_dir_q;
  logic [7:0] first_rdr_q;
  logic [7:0] first_pe_q;
  logic [7:0] second_data_q;
  logic [7:0] second_dir_q;
  logic [7:0] second_rdr_q;
  logic [7:0] second_pe_q;
  logic [7:0] edge_data_q;
  logic [7:0] edge_dir_q;
  logic [7:0] edge_rdr_q;
  logic [7:0] edge_pe_q;
  logic [7:0] edge_ps_q;
  logic [7:0] edge_ie_q;
  logic [7:0] irq_status_q;
  logic [7:0] irq_mask_q;

  // bus state
  logic wr_pend_q;
  logic rd_pend_q;
  logic [5:0] idx_q;
  logic hready_q;
  logic [31:0] hrdata_q;
  logic irq_q;

  // synchronised levels and edge events
  logic [7:0] first_level;
  logic [7:0] second_level;
  logic [7:0] edge_level;
  logic [7:0] edge_event;
  logic [7:0] first_unused_edge;
  logic [7:0] second_unused_edge;

  logic accept;
  logic [5:0] addr_idx;
  logic wr_go;
  logic rd_go;
  logic [7:0] wbyte;
  logic [7:0] rd_byte;
  logic status_rd;

  assign accept = hsel & hready & htrans[1];
  assign addr_idx = haddr[IDX_MSB:IDX_LSB];
  assign wr_go = wr_pend_q;
  assign rd_go = rd_pend_q;
  assign wbyte = hwdata[7:0];
  assign status_rd = rd_go & (idx_q == IDX_IRQ_STATUS);

  // pin cells: first and second ports have no pull select and no interrupt
  for (genvar i = 0; i < PORT_W; i++) begin : g_pins
    gpc_pin_cell #(.HAS_PS(1'b0), .HAS_IE(1'b0)) u_first (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin_i(first_pin_i[i]),
      .pin_o_q(first_pin_o[i]),
      .pin_oe_q(first_pin_oe[i]),
      .weak_q(first_pin_weak[i]),
      .pull_up_q(first_pull_up[i]),
      .pull_down_q(first_pull_down[i]),
      .dir(first_dir_q[i]),
      .out_val(first_data_q[i]),
      .reduced_drive_bit(first_rdr_q[i]),
      .pe(first_pe_q[i]),
      .ps(1'b0),
      .ie(1'b0),
      .level_q(first_level[i]),
      .edge_q(first_unused_edge[i])
    );
    gpc_pin_cell #(.HAS_PS(1'b0), .HAS_IE(1'b0)) u_second (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin_i(second_pin_i[i]),
      .pin_o_q(second_pin_o[i]),
      .pin_oe_q(second_pin_oe[i]),
      .weak_q(second_pin_weak[i]),
      .pull_up_q(second_pull_up[i]),
      .pull_down_q(second_pull_down[i]),
      .dir(second_dir_q[i]),
      .out_val(second_data_q[i]),
      .reduced_drive_bit(second_rdr_q[i]),
      .pe(second_pe_q[i]),
      .ps(1'b0),
      .ie(1'b0),
      .level_q(second_level[i]),
      .edge_q(second_unused_edge[i])
    );
    gpc_pin_cell #(.HAS_PS(1'b1), .HAS_IE(1'b1)) u_edge (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin_i(edge_pin_i[i]),
      .pin_o_q(edge_pin_o[i]),
      .pin_oe_q(edge_pin_oe[i]),
      .weak_q(edge_pin_weak[i]),
      .pull_up_q(edge_pull_up[i]),
      .pull_down_q(edge_pull_down[i]),
      .dir(edge_dir_q[i]),
      .out_val(edge_data_q[i]),
      .reduced_drive_bit(edge_rdr_q[i]),
      .pe(edge_pe_q[i]),
      .ps(edge_ps_q[i]),
      .ie(edge_ie_q[i]),
      .level_q(edge_level[i]),
      .edge_q(edge_event[i])
    );
  end

  // address phase capture; reads get one wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      idx_q <= 6'h00;
      hready_q <= 1'b1;
    end else begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      hready_q <= 1'b1;
      if (accept) begin
        idx_q <= addr_idx;
        wr_pend_q <= hwrite;
        rd_pend_q <= ~hwrite;
        hready_q <= hwrite;
      end
    end
  end

  // read mux over synchronised state
  always_comb begin
    rd_byte = RSVD_READ;
    case (idx_q)
      IDX_FIRST_DATA: rd_byte = (first_dir_q & first_data_q) |
                                (~first_dir_q & first_level);
      IDX_SECOND_DATA: rd_byte = (second_dir_q & second_data_q) |
                                 (~second_dir_q & second_level);
      IDX_FIRST_DIR: rd_byte = first_dir_q;
      IDX_SECOND_DIR: rd_byte = second_dir_q;
      IDX_FIRST_RDR: rd_byte = first_rdr_q;
      IDX_SECOND_RDR: rd_byte = second_rdr_q;
      IDX_FIRST_PE: rd_byte = first_pe_q;
      IDX_SECOND_PE: rd_byte = second_pe_q;
      IDX_EDGE_DATA: rd_byte = (edge_dir_q & edge_data_q) | (~edge_dir_q & edge_level);
      IDX_EDGE_DIR: rd_byte = edge_dir_q;
      IDX_EDGE_RDR: rd_byte = edge_rdr_q;
      IDX_EDGE_PE: rd_byte = edge_pe_q;
      IDX_EDGE_PS: rd_byte = edge_ps_q;
      IDX_EDGE_IE: rd_byte = edge_ie_q;
      IDX_IRQ_STATUS: rd_byte = irq_status_q;
      IDX_IRQ_MASK: rd_byte = irq_mask_q;
      default: rd_byte = RSVD_READ;
    endcase
  end

  // read data registered in the wait cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= RD_ZERO;
    end else if (rd_go) begin
      hrdata_q <= {24'h00_0000, rd_byte};
    end
  end

  // first and second port registers, writable at any time
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_data_q <= RST_BYTE;
      first_dir_q <= RST_BYTE;
      first_rdr_q <= RST_BYTE;
      first_pe_q <= RST_BYTE;
      second_data_q <= RST_BYTE;
      second_dir_q <= RST_BYTE;
      second_rdr_q <= RST_BYTE;
      second_pe_q <= RST_BYTE;
    end else if (wr_go) begin
      case (idx_q)
        IDX_FIRST_DATA: first_data_q <= wbyte;
        IDX_SECOND_DATA: second_data_q <= wbyte;
        IDX_FIRST_DIR: first_dir_q <= wbyte;
        IDX_SECOND_DIR: second_dir_q <= wbyte;
        IDX_FIRST_RDR: first_rdr_q <= wbyte;
        IDX_SECOND_RDR: second_rdr_q <= wbyte;
        IDX_FIRST_PE: first_pe_q <= wbyte;
        IDX_SECOND_PE: second_pe_q <= wbyte;
        default: ;
      endcase
    end
  end

  // edge port registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      edge_data_q <= RST_BYTE;
      edge_dir_q <= RST_BYTE;
      edge_rdr_q <= RST_BYTE;
      edge_pe_q <= RST_BYTE;
      edge_ps_q <= RST_BYTE;
      edge_ie_q <= RST_BYTE;
      irq_mask_q <= RST_BYTE;
    end else if (wr_go) begin
      case (idx_q)
        IDX_EDGE_DATA: edge_data_q <= wbyte;
        IDX_EDGE_DIR: edge_dir_q <= wbyte;
        IDX_EDGE_RDR: edge_rdr_q <= wbyte;
        IDX_EDGE_PE: edge_pe_q <= wbyte;
        IDX_EDGE_PS: edge_ps_q <= wbyte;
        IDX_EDGE_IE: edge_ie_q <= wbyte;
        IDX_IRQ_MASK: irq_mask_q <= wbyte;
        default: ;
      endcase
    end
  end

  // sticky edge flags; cleared by a read, a new edge wins over the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status_q <= RST_BYTE;
    end else begin
      irq_status_q <= (status_rd ? RST_BYTE : irq_status_q) | edge_event;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_status_q & irq_mask_q);
    end
  end

  assign hreadyout = hready_q;
  assign hrdata = hrdata_q;
  assign hresp = HRESP_OKAY;
  assign irq = irq_q;

  property p_read_wait;
    @(posedge hclk) disable iff (!hresetn)
      (accept && !hwrite) |=> !hreadyout ##1 hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait)
    else $error("read answer timing wrong");

  property p_data_read_output;
    @(posedge hclk) disable iff (!hresetn)
      (rd_go && idx_q == IDX_FIRST_DATA) |=>
        ((hrdata[7:0] & $past(first_dir_q)) == ($past(first_data_q) & $past(first_dir_q)));
  endproperty
  a_data_read_output: assert property (p_data_read_output)
    else $error("output pin read does not return register");

  property p_reserved_zero;
    @(posedge hclk) disable iff (!hresetn)
      (rd_go && idx_q >= IDX_RSVD_LO && idx_q <= IDX_RSVD_HI) |=> hrdata == RD_ZERO;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved location read nonzero");

  property p_dir_write;
    @(posedge hclk) disable iff (!hresetn)
      (wr_go && idx_q == IDX_SECOND_DIR) |=> ##1 second_pin_oe == $past(wbyte, 2);
  endproperty
  a_dir_write: assert property (p_dir_write)
    else $error("direction write not seen at pin enable");

  property p_no_ps_first;
    @(posedge hclk) disable iff (!hresetn)
      first_pull_down == 8'h00 && second_pull_down == 8'h00;
  endproperty
  a_no_ps_first: assert property (p_no_ps_first)
    else $error("pull-down on fixed pull-up port");

  property p_event_sets_flag;
    @(posedge hclk) disable iff (!hresetn)
      (edge_event != 8'h00) |=> ((irq_status_q & $past(edge_event)) == $past(edge_event));
  endproperty
  a_event_sets_flag: assert property (p_event_sets_flag)
    else $error("edge event lost");

  property p_irq_level;
    @(posedge hclk) disable iff (!hresetn)
      ((irq_status_q & irq_mask_q) != 8'h00) |=> irq;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt not raised");

  property p_weak_drive;
    @(posedge hclk) disable iff (!hresetn)
      (edge_dir_q[0] && !edge_rdr_q[0]) ##1 (edge_dir_q[0] && !edge_rdr_q[0]) |->
        !edge_pin_weak[0] && edge_pin_oe[0];
  endproperty
  a_weak_drive: assert property (p_weak_drive)
    else $error("full drive not selected");

endmodule : gpc_port_unit

//--- verilog/gpc_pkg.sv
package gpc_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_FIRST_DATA = 6'h00;
  localparam logic [5:0] IDX_SECOND_DATA = 6'h01;
  localparam logic [5:0] IDX_FIRST_DIR = 6'h02;
  localparam logic [5:0] IDX_SECOND_DIR = 6'h03;
  localparam logic [5:0] IDX_RSVD_LO = 6'h04;
  localparam logic [5:0] IDX_RSVD_HI = 6'h07;
  localparam logic [5:0] IDX_FIRST_RDR = 6'h10;
  localparam logic [5:0] IDX_SECOND_RDR = 6'h11;
  localparam logic [5:0] IDX_FIRST_PE = 6'h12;
  localparam logic [5:0] IDX_SECOND_PE = 6'h13;
  localparam logic [5:0] IDX_EDGE_DATA = 6'h20;
  localparam logic [5:0] IDX_EDGE_DIR = 6'h21;
  localparam logic [5:0] IDX_EDGE_RDR = 6'h22;
  localparam logic [5:0] IDX_EDGE_PE = 6'h23;
  localparam logic [5:0] IDX_EDGE_PS = 6'h24;
  localparam logic [5:0] IDX_EDGE_IE = 6'h25;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h26;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h27;

  // address bits that carry the index
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 7;

  localparam int PORT_W = 8;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RSVD_READ = 8'h00;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

endpackage : gpc_pkg

//--- verilog/gpc_pin_cell.sv
`timescale 1ns/1ps
module gpc_pin_cell
  import gpc_pkg::*;
#(
  parameter bit HAS_PS = 1'b1,
  parameter bit HAS_IE = 1'b1
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // pin side
  input wire logic pin_i,
  output logic pin_o_q,
  output logic pin_oe_q,
  output logic weak_q,
  output logic pull_up_q,
  output logic pull_down_q,
  // configuration
  input wire logic dir,
  input wire logic out_val,
  input wire logic reduced_drive_bit,
  input wire logic pe,
  input wire logic ps,
  input wire logic ie,
  // status
  output logic level_q,
  output logic edge_q
);

  logic [2:0] sync_q;
  logic agree;
  logic ps_eff;
  logic rise;
  logic fall;

  assign ps_eff = HAS_PS & ps;
  assign agree = (sync_q[1] == sync_q[2]);
  assign rise = agree & sync_q[2] & ~level_q;
  assign fall = agree & ~sync_q[2] & level_q;

  // three-stage input synchroniser, level taken once stages two and three agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_q <= 3'h0;
      level_q <= 1'b0;
    end else begin
      sync_q <= {sync_q[1:0], pin_i};
      if (agree) begin
        level_q <= sync_q[2];
      end
    end
  end

  // edge detect works in input and output mode alike
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      edge_q <= 1'b0;
    end else begin
      edge_q <= HAS_IE & ie & (ps_eff ? rise : fall);
    end
  end

  // drivers and pull devices
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_o_q <= 1'b0;
      pin_oe_q <= 1'b0;
      weak_q <= 1'b0;
      pull_up_q <= 1'b0;
      pull_down_q <= 1'b0;
    end else begin
      pin_oe_q <= dir;
      pin_o_q <= out_val;
      weak_q <= dir & reduced_drive_bit;
      pull_up_q <= pe & ~dir & ~ps_eff;
      pull_down_q <= pe & ~dir & ps_eff;
    end
  end

  property p_pull_off_output;
    @(posedge hclk) disable iff (!hresetn)
      dir ##1 dir |-> !pull_up_q && !pull_down_q;
  endproperty
  a_pull_off_output: assert property (p_pull_off_output)
    else $error("pull device active on output pin");

  property p_pull_select;
    @(posedge hclk) disable iff (!hresetn)
      (pe && !dir && ps_eff) ##1 (pe && !dir && ps_eff) |-> pull_down_q && !pull_up_q;
  endproperty
  a_pull_select: assert property (p_pull_select)
    else $error("pull select does not give pull-down");

  property p_rise_edge;
    @(posedge hclk) disable iff (!hresetn)
      (HAS_IE && ie && ps_eff && rise) |=> edge_q;
  endproperty
  a_rise_edge: assert property (p_rise_edge)
    else $error("rising edge missed");

  property p_no_edge_without_ie;
    @(posedge hclk) disable iff (!hresetn)
      $past(!ie) |-> !edge_q;
  endproperty
  a_no_edge_without_ie: assert property (p_no_edge_without_ie)
    else $error("edge flagged with interrupt disabled");

endmodule : gpc_pin_cell

//--- tb/gpc_board_model.sv
`timescale 1ns/1ps
module gpc_board_model (
  // design side
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pull_up,
  input wire logic [7:0] pull_down,
  // board drivers
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  // resolved pad level
  output logic [7:0] pin_i
);
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      if (pin_oe[b]) begin
        pin_i[b] = pin_o[b];
      end else if (ext_en[b]) begin
        pin_i[b] = ext_val[b];
      end else if (pull_up[b]) begin
        pin_i[b] = 1'b1;
      end else if (pull_down[b]) begin
        pin_i[b] = 1'b0;
      end else begin
        // floating pad: always reads the inverse of pin_o
        pin_i[b] = ~pin_o[b];
      end
    end
  end
endmodule : gpc_board_model

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import gpc_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hreadyout, hresp, irq;
  logic [31:0] hrdata;
  logic [7:0] f_i, f_o, f_oe, f_wk, f_pu, f_pd;
  logic [7:0] s_i, s_o, s_oe, s_wk, s_pu, s_pd;
  logic [7:0] e_i, e_o, e_oe, e_wk, e_pu, e_pd;
  logic [7:0] f_xv = 8'h00, f_xe = 8'hFF, s_xv = 8'h00, s_xe = 8'hFF, e_xv = 8'h00, e_xe = 8'hFF;
  int error_cnt = 0;
  int checks_done = 0;

  always #25 hclk = ~hclk;

  gpc_port_unit u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .first_pin_i(f_i), .first_pin_o(f_o), .first_pin_oe(f_oe), .first_pin_weak(f_wk),
    .first_pull_up(f_pu), .first_pull_down(f_pd),
    .second_pin_i(s_i), .second_pin_o(s_o), .second_pin_oe(s_oe), .second_pin_weak(s_wk),
    .second_pull_up(s_pu), .second_pull_down(s_pd),
    .edge_pin_i(e_i), .edge_pin_o(e_o), .edge_pin_oe(e_oe), .edge_pin_weak(e_wk),
    .edge_pull_up(e_pu), .edge_pull_down(e_pd), .irq(irq));

  gpc_board_model u_fb (.pin_o(f_o), .pin_oe(f_oe), .pull_up(f_pu), .pull_down(f_pd),
    .ext_val(f_xv), .ext_en(f_xe), .pin_i(f_i));
  gpc_board_model u_sb (.pin_o(s_o), .pin_oe(s_oe), .pull_up(s_pu), .pull_down(s_pd),
    .ext_val(s_xv), .ext_en(s_xe), .pin_i(s_i));
  gpc_board_model u_eb (.pin_o(e_o), .pin_oe(e_oe), .pull_up(e_pu), .pull_down(e_pd),
    .ext_val(e_xv), .ext_en(e_xe), .pin_i(e_i));

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one single transfer; entered just after a rising edge
  // waits as long as the slave stalls; only the watchdog ends a hang
  task automatic bus(input logic [5:0] i, input logic w, input logic [7:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, i, 2'b00};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= 3'h2;
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= HTRANS_IDLE;
    hwdata <= {24'h00_0000, d};
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus

  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    logic [31:0] x;
    bus(i, 1'b1, d, x);
  endtask : wr

  task automatic rdc(input string n, input logic [5:0] i, input logic [7:0] e);
    logic [31:0] x;
    bus(i, 1'b0, 8'h00, x);
    check(n, x, {24'h00_0000, e});
  endtask : rdc

  task automatic gap(input int n);
    repeat (n) @(posedge hclk);
  endtask : gap

  task automatic t_reset;
    check("hresp", hresp, HRESP_OKAY);
    check("irq reset", irq, 1'b0);
    check("f_oe reset", f_oe, 8'h00);
    rdc("dir reset", IDX_SECOND_DIR, RST_BYTE);
    $display("test reset done");
  endtask : t_reset

  task automatic t_data;
    wr(IDX_FIRST_DIR, 8'hFF);
    wr(IDX_FIRST_DATA, 8'hA5);
    gap(3);
    check("f_o", f_o, 8'hA5);
    check("f_oe", f_oe, 8'hFF);
    check("f_wk", f_wk, 8'h00);
    rdc("first data", IDX_FIRST_DATA, 8'hA5);
    rdc("first dir", IDX_FIRST_DIR, 8'hFF);
    wr(IDX_FIRST_RDR, 8'hFF);
    gap(3);
    check("f_wk", f_wk, 8'hFF);
    s_xe <= 8'hF0;
    s_xv <= 8'h96;
    wr(IDX_SECOND_DIR, 8'h0F);
    wr(IDX_SECOND_DATA, 8'h3C);
    gap(6);
    check("s_o", s_o, 8'h3C);
    check("s_oe", s_oe, 8'h0F);
    rdc("second data", IDX_SECOND_DATA, 8'h9C);
    wr(IDX_SECOND_PE, 8'hFF);
    gap(3);
    check("s_pu", s_pu, 8'hF0);
    check("s_pd", s_pd, 8'h00);
    check("s_wk", s_wk, 8'h00);
    $display("test data done");
  endtask : t_data

  task automatic t_pull;
    wr(IDX_FIRST_DIR, 8'h00);
    wr(IDX_FIRST_PE, 8'hFF);
    f_xe <= 8'h00;
    gap(6);
    check("f_pu", f_pu, 8'hFF);
    check("f_pd", f_pd, 8'h00);
    rdc("first pulled", IDX_FIRST_DATA, 8'hFF);
    wr(IDX_FIRST_DIR, 8'hF0);
    gap(3);
    check("f_pu out", f_pu, 8'h0F);
    e_xe <= 8'h00;
    wr(IDX_EDGE_PE, 8'hFF);
    wr(IDX_EDGE_PS, 8'hF0);
    gap(6);
    check("e_pu", e_pu, 8'h0F);
    check("e_pd", e_pd, 8'hF0);
    rdc("edge pulled", IDX_EDGE_DATA, 8'h0F);
    wr(IDX_EDGE_DIR, 8'hFF);
    gap(3);
    check("e_pd out", e_pd, 8'h00);
    wr(IDX_EDGE_DIR, 8'h00);
    wr(IDX_EDGE_PE, 8'h00);
    e_xe <= 8'hFF;
    $display("test pull done");
  endtask : t_pull

  task automatic t_rsvd;
    for (int k = 4; k < 8; k++) begin
      wr(k[5:0], 8'hFF);
      rdc("reserved", k[5:0], RSVD_READ);
    end
    rdc("unmapped", 6'h3F, 8'h00);
    rdc("dir kept", IDX_FIRST_DIR, 8'hF0);
    $display("test reserved done");
  endtask : t_rsvd

  task automatic t_irq;
    e_xv <= 8'h00;
    wr(IDX_EDGE_PS, 8'h01);
    wr(IDX_EDGE_IE, 8'h03);
    wr(IDX_IRQ_MASK, 8'h03);
    gap(8);
    rdc("status idle", IDX_IRQ_STATUS, 8'h00);
    e_xv <= 8'h01;
    gap(8);
    check("irq rise", irq, 1'b1);
    rdc("status rise", IDX_IRQ_STATUS, 8'h01);
    rdc("status clr", IDX_IRQ_STATUS, 8'h00);
    gap(2);
    check("irq clr", irq, 1'b0);
    e_xv <= 8'h02;
    gap(8);
    rdc("no fall b0 rise b1", IDX_IRQ_STATUS, 8'h00);
    e_xv <= 8'h00;
    gap(8);
    rdc("fall b1", IDX_IRQ_STATUS, 8'h02);
    wr(IDX_IRQ_MASK, 8'h00);
    e_xv <= 8'h01;
    gap(8);
    check("irq masked", irq, 1'b0);
    rdc("masked status", IDX_IRQ_STATUS, 8'h01);
    // release the board driver right after the direction write, one cycle before the pin drives itself high
    wr(IDX_EDGE_DATA, 8'h02);
    wr(IDX_EDGE_DIR, 8'h02);
    e_xe <= 8'hFD;
    gap(8);
    check("e_oe", e_oe, 8'h02);
    check("e_o", e_o, 8'h02);
    check("e_wk", e_wk, 8'h00);
    rdc("status pre", IDX_IRQ_STATUS, 8'h00);
    wr(IDX_EDGE_DATA, 8'h00);
    gap(8);
    rdc("output fall", IDX_IRQ_STATUS, 8'h02);
    wr(IDX_IRQ_MASK, 8'hFF);
    f_xe <= 8'hFF;
    f_xv <= 8'hFF;
    gap(8);
    f_xv <= 8'h00;
    gap(8);
    check("irq first port", irq, 1'b0);
    rdc("status first port", IDX_IRQ_STATUS, 8'h00);
    $display("test irq done");
  endtask : t_irq

  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_data();
    t_pull();
    t_rsvd();
    t_irq();
    give_verdict();
  end

  initial begin
    repeat (5000) @(posedge hclk);
    error_cnt++;
    give_verdict();
  end
endmodule : testbench
